// File: src/sdma_regs_pkg.sv
// Package with offsets, widths and encodings of the slave DMA register block.
package sdma_regs_pkg;

  // ----------------------------------------------------------------------
  // Direct-mapped I/O locations.
  // ----------------------------------------------------------------------
  localparam logic [15:0] IO_CH0_ADDR = 16'h0000; // Channel 0 memory address.
  localparam logic [15:0] IO_CH0_COUNT = 16'h0001; // Channel 0 transfer count.
  localparam logic [15:0] IO_CH1_ADDR = 16'h0002; // Channel 1 memory address.
  localparam logic [15:0] IO_CH1_COUNT = 16'h0003; // Channel 1 transfer count.
  localparam logic [15:0] IO_CH2_ADDR = 16'h0004; // Channel 2 memory address.
  localparam logic [15:0] IO_CH2_COUNT = 16'h0005; // Channel 2 transfer count.
  localparam logic [15:0] IO_BP_CLEAR = 16'h000C; // Byte pointer clear, write only.

  // ----------------------------------------------------------------------
  // Memory-mapped configuration space.
  // ----------------------------------------------------------------------
  localparam logic [11:0] MM_CH7_NEXT_COUNT_HIGH = 12'hDBE; // Next count bits 23..16.

  // ----------------------------------------------------------------------
  // Field layout.
  // ----------------------------------------------------------------------
  localparam int NUM_CH = 3; // Slave channels covered here.
  localparam logic [7:0] RESET_BYTE = 8'h00; // Reset value of every byte.
  localparam logic [7:0] UNMAPPED_READ = 8'h00; // Read data of an unmapped access.

  // Byte-pointer state: which half the next access reaches.
  typedef enum logic [0:0] {
    BP_LOW = 1'b0,
    BP_HIGH = 1'b1
  } byte_ptr_t;

endpackage

// File: src/sdma_io_decode.sv
// Decoder for the slave DMA direct-mapped I/O locations.
`timescale 1ns/100ps
module sdma_io_decode
  import sdma_regs_pkg::*;
(
  input wire logic [15:0] io_addr_in, // I/O address.
  output logic hit_out, // Address or count location hit.
  output logic is_count_out, // High for a count location.
  output logic [1:0] chan_out, // Channel number.
  output logic bp_clear_out // Byte pointer clear location hit.
);

  // ----------------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------------
  // Pure address compare; strobes are qualified by the caller.
  always_comb begin
    hit_out = 1'b1;
    is_count_out = 1'b0;
    chan_out = 2'h0;
    bp_clear_out = 1'b0;
    case (io_addr_in)
      IO_CH0_ADDR: begin
        chan_out = 2'h0;
      end
      IO_CH0_COUNT: begin
        is_count_out = 1'b1;
        chan_out = 2'h0;
      end
      IO_CH1_ADDR: begin
        chan_out = 2'h1;
      end
      IO_CH1_COUNT: begin
        is_count_out = 1'b1;
        chan_out = 2'h1;
      end
      IO_CH2_ADDR: begin
        chan_out = 2'h2;
      end
      IO_CH2_COUNT: begin
        is_count_out = 1'b1;
        chan_out = 2'h2;
      end
      IO_BP_CLEAR: begin
        hit_out = 1'b0;
        bp_clear_out = 1'b1;
      end
      default: begin
        hit_out = 1'b0; // Unmapped: nothing selected.
      end
    endcase
  end

endmodule

// File: src/sdma_regs.sv
// Slave DMA channel 0-2 address and count registers with channel 7 chaining byte.
// Function
// - Chaining byte holds next count bits 23-16.
// - Chaining byte ignored when chaining disabled.
// - Chaining byte at memory offset DBE, bits 7-0.
// - Sixteen-bit values reached through one byte location.
// - First address access after clear: bits 7-0.
// - Next address access: bits 15-8.
// - First count access after clear: bits 7-0.
// - Next count access: bits 15-8.
// - Transfers equal programmed count plus one.
// - Address 27-0 joins extended page, page, address.
// - Registers track live address and count.
// - I/O decode of channel address and count.
`timescale 1ns/100ps
module sdma_regs
  import sdma_regs_pkg::*;
#(
  parameter int CH = NUM_CH // Number of slave channels.
) (
  input wire logic clk_in, // 10 MHz system clock.
  input wire logic nrst_in, // Asynchronous active-low reset.
  input wire logic [15:0] io_addr_in, // I/O address.
  input wire logic io_wr_in, // I/O write strobe, one cycle.
  input wire logic io_rd_in, // I/O read strobe, one cycle.
  input wire logic [7:0] io_wdata_in, // I/O write data.
  output logic [7:0] io_rdata_out, // I/O read data, registered.
  input wire logic [11:0] mm_addr_in, // Configuration space offset.
  input wire logic mm_wr_in, // Configuration write strobe.
  input wire logic mm_rd_in, // Configuration read strobe.
  input wire logic [7:0] mm_wdata_in, // Configuration write data.
  output logic [7:0] mm_rdata_out, // Configuration read data, registered.
  input wire logic [CH*8-1:0] page_in, // Page registers, per channel.
  input wire logic [CH*4-1:0] ext_page_in, // Extended page registers.
  input wire logic [CH-1:0] xfer_step_in, // Engine moved one transfer.
  input wire logic ch7_chain_enable_in, // Chaining enabled for channel 7.
  input wire logic ch7_chain_load_in, // Channel 7 moves to next buffer.
  output logic [CH*28-1:0] dma_addr_out, // Full 28-bit address per channel.
  output logic [CH*17-1:0] xfer_total_out, // Transfers to do per channel.
  output logic [CH-1:0] terminal_out, // Count expired, per channel.
  output logic [7:0] ch7_count_high_out // Count bits 23..16 loaded into channel 7.
);

  // ----------------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [CH-1:0][15:0] addr; // Current memory address per channel.
    logic [CH-1:0][15:0] count; // Current count per channel.
    logic [CH-1:0] done; // Count expired.
    byte_ptr_t ptr; // Shared byte pointer.
    logic [7:0] ch7_next_high; // Chaining next count high byte.
    logic [7:0] ch7_loaded; // Byte taken by channel 7.
    logic [7:0] io_rdata; // Registered I/O read data.
    logic [7:0] mm_rdata; // Registered configuration read data.
    logic [CH-1:0][27:0] full_addr; // Registered full address.
    logic [CH-1:0][16:0] total; // Registered transfer total.
  } state_t;

  state_t cur; // Registered state.
  state_t next_st; // Next state.
  logic hit; // Address or count location.
  logic is_count; // Count location.
  logic [1:0] chan; // Selected channel.
  logic bp_clear; // Clear location.
  logic access; // Any read or write of a data location.
  logic chan_ok; // Selected channel exists.

  // Picks the selected byte of a 16-bit value.
  function automatic logic [7:0] pick(input logic [15:0] v, input byte_ptr_t p);
    pick = (p == BP_HIGH) ? v[15:8] : v[7:0];
  endfunction

  // Replaces the selected byte of a 16-bit value.
  function automatic logic [15:0] put(input logic [15:0] v, input byte_ptr_t p,
                                      input logic [7:0] b);
    put = (p == BP_HIGH) ? {b, v[7:0]} : {v[15:8], b};
  endfunction

  sdma_io_decode u_dec (
    .io_addr_in(io_addr_in),
    .hit_out(hit),
    .is_count_out(is_count),
    .chan_out(chan),
    .bp_clear_out(bp_clear)
  );

  assign chan_ok = 32'(chan) < CH;
  assign access = hit && chan_ok && (io_wr_in || io_rd_in);

  // ----------------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------------
  // A host access takes priority over an engine step on the same channel,
  // so software sees exactly what it wrote rather than a racing update.
  always_comb begin
    next_st = cur;
    next_st.io_rdata = UNMAPPED_READ;
    next_st.mm_rdata = UNMAPPED_READ;
    // Engine steps: address counts up, count counts down; reaching zero
    // already stands for the last transfer, so total is count plus one.
    for (int i = 0; i < CH; i++) begin
      if (xfer_step_in[i] && !cur.done[i]) begin
        next_st.addr[i] = cur.addr[i] + 16'h0001;
        if (cur.count[i] == 16'h0000) begin
          next_st.done[i] = 1'b1;
        end else begin
          next_st.count[i] = cur.count[i] - 16'h0001;
        end
      end
    end
    if (access) begin
      if (io_rd_in) begin
        next_st.io_rdata = is_count ? pick(cur.count[chan], cur.ptr)
                                    : pick(cur.addr[chan], cur.ptr);
      end
      if (io_wr_in && is_count) begin
        next_st.count[chan] = put(cur.count[chan], cur.ptr, io_wdata_in);
        // Reprogramming clears the expiry, but an expiry raised in this same
        // cycle wins, so a terminal event is never lost to a racing write.
        if (!(xfer_step_in[chan] && !cur.done[chan] && cur.count[chan] == 16'h0000)) begin
          next_st.done[chan] = 1'b0;
        end
      end else if (io_wr_in) begin
        next_st.addr[chan] = put(cur.addr[chan], cur.ptr, io_wdata_in);
      end
      // Every access flips the pointer so the pair alternates.
      next_st.ptr = (cur.ptr == BP_LOW) ? BP_HIGH : BP_LOW;
    end else if (bp_clear && io_wr_in) begin
      next_st.ptr = BP_LOW;
    end
    // Chaining byte in configuration space.
    if (mm_wr_in && mm_addr_in == MM_CH7_NEXT_COUNT_HIGH) begin
      next_st.ch7_next_high = mm_wdata_in;
    end
    if (mm_rd_in && mm_addr_in == MM_CH7_NEXT_COUNT_HIGH) begin
      next_st.mm_rdata = cur.ch7_next_high;
    end
    // Without chaining the stored byte has no effect on channel 7.
    if (ch7_chain_load_in && ch7_chain_enable_in) begin
      next_st.ch7_loaded = cur.ch7_next_high;
    end
    for (int i = 0; i < CH; i++) begin
      next_st.full_addr[i] = {ext_page_in[i*4 +: 4], page_in[i*8 +: 8],
                              next_st.addr[i]};
      next_st.total[i] = {1'b0, next_st.count[i]} + 17'h00001;
    end
  end

  // ----------------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cur <= '0;
      for (int i = 0; i < CH; i++) begin
        cur.total[i] <= 17'h00001;
      end
    end else begin
      cur <= next_st;
    end
  end

  // Outputs come straight from the registered state.
  assign io_rdata_out = cur.io_rdata;
  assign mm_rdata_out = cur.mm_rdata;
  assign dma_addr_out = cur.full_addr;
  assign xfer_total_out = cur.total;
  assign terminal_out = cur.done;
  assign ch7_count_high_out = cur.ch7_loaded;

  // ----------------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------------
  sequence s_clear;
    io_wr_in && bp_clear;
  endsequence
  sequence s_access;
    access;
  endsequence

  a_ptr_clear_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_clear |=> cur.ptr == BP_LOW) else $error("pointer not low after clear");
  a_ptr_toggle_each: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_access |=> cur.ptr != $past(cur.ptr)) else $error("pointer did not toggle");
  a_low_addr_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (io_wr_in && access && !is_count && cur.ptr == BP_LOW)
    |=> cur.addr[$past(chan)][7:0] == $past(io_wdata_in)) else $error("address low wrong");
  a_high_count_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (io_wr_in && access && is_count && cur.ptr == BP_HIGH)
    |=> cur.count[$past(chan)][15:8] == $past(io_wdata_in)) else $error("count high wrong");
  // The host leaves one idle cycle between strobes, so the low access that
  // follows a clear lands two cycles after it.
  a_pair_sequence: assert property (@(posedge clk_in) disable iff (!nrst_in)
    s_clear ##1 (!access)[*1] ##1 s_access |=> cur.ptr == BP_HIGH)
    else $error("pair order broken");
  a_count_read_low: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (io_rd_in && access && is_count && cur.ptr == BP_LOW)
    |=> io_rdata_out == $past(cur.count[chan][7:0])) else $error("count read wrong");
  a_total_plus_one: assert property (@(posedge clk_in) disable iff (!nrst_in)
    xfer_total_out[16:0] == {1'b0, $past(next_st.count[0])} + 17'h00001)
    else $error("total not count plus one");
  a_chain_ignored: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !ch7_chain_enable_in |=> $stable(ch7_count_high_out)) else $error("chain byte used");
  a_chain_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (mm_rd_in && mm_addr_in == MM_CH7_NEXT_COUNT_HIGH)
    |=> mm_rdata_out == $past(cur.ch7_next_high)) else $error("chain read wrong");
  // The join is held against the page inputs of the cycle before, so the
  // page and extended page bits are covered and not only the low half.
  a_full_address: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $past(nrst_in) |-> dma_addr_out[27:0] == {$past(ext_page_in[3:0]),
                                             $past(page_in[7:0]), cur.addr[0]})
    else $error("address join wrong");
  // A step that meets a zero count must raise the expiry one cycle later,
  // even when a count write arrives in the same cycle.
  a_expire_on_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (xfer_step_in[CH-1] && !cur.done[CH-1] && cur.count[CH-1] == 16'h0000)
    |=> terminal_out[CH-1]) else $error("expiry not flagged");
  // Accesses outside the decoded locations must not disturb the pair order.
  a_unmapped_keeps_ptr: assert property (@(posedge clk_in) disable iff (!nrst_in)
    (!access && !(io_wr_in && bp_clear)) |=> $stable(cur.ptr))
    else $error("pointer moved without access");

endmodule

// File: sim/sdma_host_model.sv
// Host processor model that makes byte accesses on the I/O and configuration buses.
`timescale 1ns/100ps
module sdma_host_model
  import sdma_regs_pkg::*;
(
  input wire logic clk_in, // System clock.
  input wire logic [7:0] io_rdata_in, // I/O read data.
  input wire logic [7:0] mm_rdata_in, // Configuration read data.
  output logic [15:0] io_addr_out, // I/O address.
  output logic io_wr_out, // I/O write strobe.
  output logic io_rd_out, // I/O read strobe.
  output logic [7:0] io_wdata_out, // I/O write data.
  output logic [11:0] mm_addr_out, // Configuration offset.
  output logic mm_wr_out, // Configuration write strobe.
  output logic mm_rd_out, // Configuration read strobe.
  output logic [7:0] mm_wdata_out // Configuration write data.
);
  // Idle bus at time zero.
  initial begin
    {io_addr_out, io_wr_out, io_rd_out, io_wdata_out} = '0;
    {mm_addr_out, mm_wr_out, mm_rd_out, mm_wdata_out} = '0;
  end
  // One strobe cycle; released lines flip so stale values are never seen.
  task automatic iow(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {io_addr_out, io_wdata_out, io_wr_out} <= {a, d, 1'b1};
    @(posedge clk_in);
    {io_addr_out, io_wdata_out, io_wr_out} <= {~a, ~d, 1'b0};
  endtask
  // Read data is registered, so it is taken just after the strobe edge.
  task automatic ior(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_in);
    {io_addr_out, io_rd_out} <= {a, 1'b1};
    @(posedge clk_in);
    {io_addr_out, io_rd_out} <= {~a, 1'b0};
    #1 d = io_rdata_in;
  endtask
  // Software clears the pointer so the low byte always comes first.
  task automatic clr();
    iow(IO_BP_CLEAR, 8'h00);
  endtask
  task automatic mmw(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_in);
    {mm_addr_out, mm_wdata_out, mm_wr_out} <= {a, d, 1'b1};
    @(posedge clk_in);
    {mm_addr_out, mm_wdata_out, mm_wr_out} <= {~a, ~d, 1'b0};
  endtask
  task automatic mmr(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_in);
    {mm_addr_out, mm_rd_out} <= {a, 1'b1};
    @(posedge clk_in);
    {mm_addr_out, mm_rd_out} <= {~a, 1'b0};
    #1 d = mm_rdata_in;
  endtask
endmodule

// File: sim/slave_dma_addr_count_regs_test.sv
// Self-checking testbench of the slave DMA address and count registers.
`timescale 1ns/100ps
module slave_dma_addr_count_regs_test;
  import sdma_regs_pkg::*;
  logic clk_in = 1'b0; // System clock.
  logic nrst_in = 1'b0; // Reset, active low.
  logic [15:0] io_addr;
  logic io_wr, io_rd, mm_wr, mm_rd;
  logic [7:0] io_wdata, io_rdata, mm_wdata, mm_rdata, ch7_high, d, e;
  logic [11:0] mm_addr;
  logic [23:0] page = 24'hC3B2A1; // Page inputs, levels.
  logic [11:0] ext_page = 12'h987; // Extended page inputs.
  logic [2:0] step = 3'b000; // Engine transfer pulses.
  logic chain_en = 1'b0, chain_load = 1'b0; // Chaining controls.
  logic [83:0] dma_addr;
  logic [50:0] total;
  logic [2:0] term;
  int bad_count = 0, n_tests = 0, cycles = 0;
  always #50 clk_in = ~clk_in; // 10 MHz.
  sdma_host_model host (.clk_in(clk_in), .io_rdata_in(io_rdata), .mm_rdata_in(mm_rdata),
    .io_addr_out(io_addr), .io_wr_out(io_wr), .io_rd_out(io_rd), .io_wdata_out(io_wdata),
    .mm_addr_out(mm_addr), .mm_wr_out(mm_wr), .mm_rd_out(mm_rd), .mm_wdata_out(mm_wdata));
  sdma_regs dut (.clk_in(clk_in), .nrst_in(nrst_in), .io_addr_in(io_addr), .io_wr_in(io_wr),
    .io_rd_in(io_rd), .io_wdata_in(io_wdata), .io_rdata_out(io_rdata), .mm_addr_in(mm_addr),
    .mm_wr_in(mm_wr), .mm_rd_in(mm_rd), .mm_wdata_in(mm_wdata), .mm_rdata_out(mm_rdata),
    .page_in(page), .ext_page_in(ext_page), .xfer_step_in(step),
    .ch7_chain_enable_in(chain_en), .ch7_chain_load_in(chain_load), .dma_addr_out(dma_addr),
    .xfer_total_out(total), .terminal_out(term), .ch7_count_high_out(ch7_high));
  // Compare and count; an unknown never matches.
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  // Full 28-bit address of a channel as the engine should see it.
  function automatic logic [31:0] full(input int c, input logic [15:0] a);
    return {4'h0, ext_page[c*4+:4], page[c*8+:8], a};
  endfunction
  // Writes a 16-bit value as two bytes after a pointer clear.
  task automatic w16(input logic [15:0] a, input logic [15:0] v);
    host.clr();
    host.iow(a, v[7:0]);
    host.iow(a, v[15:8]);
    @(posedge clk_in);
    #1;
  endtask
  // Address bytes land in order and join the page inputs, on every channel.
  task automatic t_addr();
    for (int c = 0; c < 3; c++) begin
      w16(16'(2 * c), {8'h12 + 8'(c), 8'h34});
      chk("dma_addr", full(c, {8'h12 + 8'(c), 8'h34}), 32'(dma_addr[c*28+:28]));
      host.clr();
      host.ior(16'(2 * c), d);
      host.ior(16'(2 * c), e);
      chk("addr_read", {8'h12 + 8'(c), 8'h34}, 32'({e, d}));
    end
  endtask
  // Count of zero gives one transfer; the largest count gives 65536.
  task automatic t_count();
    logic [15:0] tbl [2];
    tbl = '{16'h0000, 16'hFFFF};
    foreach (tbl[i]) begin
      w16(IO_CH1_COUNT, tbl[i]);
      chk("xfer_total", 32'(17'(tbl[i]) + 17'h1), 32'(total[17+:17]));
      host.clr();
      host.ior(IO_CH1_COUNT, d);
      host.ior(IO_CH1_COUNT, e);
      chk("count_read", 32'(tbl[i]), 32'({e, d}));
    end
  endtask
  // One pointer is shared; unmapped accesses leave it alone and read 0.
  task automatic t_shared();
    host.clr();
    host.iow(IO_CH0_ADDR, 8'h55);
    host.iow(IO_CH0_COUNT, 8'h66);
    host.iow(16'h0040, 8'hEE);
    @(posedge clk_in);
    #1;
    chk("total_ch0", 32'h6601, 32'(total[16:0]));
    host.iow(IO_CH0_ADDR, 8'h77);
    @(posedge clk_in);
    #1;
    chk("addr_ch0", full(0, 16'h1277), 32'(dma_addr[27:0]));
    host.ior(16'h0040, d);
    chk("unmapped_read", 32'h0, 32'(d));
  endtask
  // Engine pulses on channel 2 move the live address and count.
  task automatic pulse2();
    @(posedge clk_in);
    step <= 3'b100;
    @(posedge clk_in);
    step <= 3'b000;
    @(posedge clk_in);
    #1;
  endtask
  task automatic t_step();
    w16(IO_CH2_ADDR, 16'h00FF);
    w16(IO_CH2_COUNT, 16'h0001);
    pulse2();
    chk("live_addr", full(2, 16'h0100), 32'(dma_addr[56+:28]));
    chk("live_total", 32'h1, 32'(total[34+:17]));
    chk("terminal", 32'h0, 32'(term));
    pulse2();
    chk("terminal", 32'h4, 32'(term));
    w16(IO_CH2_COUNT, 16'h0003);
    chk("terminal", 32'h0, 32'(term));
  endtask
  // Chaining byte at its offset is loaded only while chaining is on.
  task automatic load7(input logic en);
    @(posedge clk_in);
    {chain_en, chain_load} <= {en, 1'b1};
    @(posedge clk_in);
    chain_load <= 1'b0;
    @(posedge clk_in);
    #1;
  endtask
  task automatic t_chain();
    host.mmw(MM_CH7_NEXT_COUNT_HIGH, 8'h5A);
    host.mmr(MM_CH7_NEXT_COUNT_HIGH, d);
    chk("chain_read", 32'h5A, 32'(d));
    load7(1'b0);
    chk("ch7_high", 32'h0, 32'(ch7_high));
    load7(1'b1);
    chk("ch7_high", 32'h5A, 32'(ch7_high));
  endtask
  task automatic print_verdict();
    $display("Checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // A hang counts as a mismatch; the tests need well under 3000 cycles.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end
  // Main sequence: reset for five cycles, then every scenario in turn.
  initial begin
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    #1;
    chk("reset_total", 32'h1, 32'(total[16:0]));
    chk("reset_addr", 32'h0, 32'(dma_addr[27:16]));
    t_addr();
    t_count();
    t_shared();
    t_step();
    t_chain();
    print_verdict();
  end
endmodule
